// ===== tb/spi_frame_format_control_bench.sv
`timescale 1ns/1ps
module spi_frame_format_control_bench
  import spi_frame_pkg::*;
;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, sck_i = 0, bsdi = 0, ss_n = 1, slv = 0, p_load = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd_r;
  logic [1:0] htrans = 0;
  logic hready, hresp, sck_o, sck_oe, sck_w, sdi, psdi, sdo_o, sdo_oe;
  logic [15:0] ptx = 0, prx, ctl = 0, w, msk;
  logic [7:0] rxw = 8'h00;
  logic [3:0] cfgs [4] = '{4'h0, 4'hF, 4'h6, 4'h9};
  int pedges, n_fail = 0, checks_done = 0, cycles = 0, nb;
  assign sck_w = sck_oe ? sck_o : sck_i;
  assign sdi = slv ? bsdi : psdi;
  always #25 clk = ~clk;
  spi_frame_port #(.HALF_CYCLES(4), .FIFO_DEPTH(16)) i_spi_frame_port (.CLK(clk), .RESET_N(rst_n), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE(sck_oe),
    .SDI(sdi), .SDO_O(sdo_o), .SDO_OE(sdo_oe), .SLAVE_SELECT_PIN_N(ss_n));
  spi_partner i_spi_partner (.load(p_load), .sck(sck_w), .sdo(sdo_o), .pol(ctl[POLARITY_BIT]),
    .edge_sel(ctl[EDGE_SELECT_BIT]), .tx_word(ptx), .sdi(psdi), .rx_word(prx), .edges(pedges));
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [15:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd_r = hrdata;
  endtask : ahb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic poll(input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, ADDR_STATUS, 16'h0);
    for (int i = 0; i < 1000 && (rd_r & m) !== e; i++) ahb(1'b0, ADDR_STATUS, 16'h0);
    chk(rd_r & m, e);
  endtask : poll
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ahb(1'b0, ADDR_CTRL, 16'h0);
    chk(rd_r, {16'h0, CTRL_RESET});
    ahb(1'b1, ADDR_CTRL, 16'hFFFF);
    ahb(1'b0, ADDR_CTRL, 16'h0);
    chk(rd_r, {16'h0, CTRL_MASK});
    ahb(1'b1, 8'h10, 16'hFFFF);
    ahb(1'b0, 8'h10, 16'h0);
    chk(rd_r, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("Test registers done");
    for (int i = 0; i < 4; i++) begin
      nb = cfgs[i][3] ? 16 : 8;
      msk = cfgs[i][3] ? 16'hFFFF : 16'h00FF;
      ctl = 16'h0;
      ctl[CTRL_ENABLE_BIT] = 1'b1;
      ctl[MASTER_BIT] = 1'b1;
      {ctl[WORD_WIDTH_BIT], ctl[SAMPLE_PHASE_BIT], ctl[EDGE_SELECT_BIT], ctl[POLARITY_BIT]} = cfgs[i];
      ahb(1'b1, ADDR_CTRL, ctl);
      w = 16'hC3A5 ^ 16'(i * 16'h1111);
      ptx = (nb == 16) ? w : {w[7:0], 8'h00};
      repeat (2) @(posedge clk);
      p_load <= 1'b1;
      @(posedge clk);
      p_load <= 1'b0;
      ahb(1'b1, ADDR_TXDATA, ~w);
      poll(32'h9, 32'h8);
      ahb(1'b0, ADDR_RXDATA, 16'h0);
      chk(rd_r, {16'h0, w & msk});
      chk({16'h0, prx & msk}, {16'h0, ~w & msk});
      chk(32'(pedges), 32'(2 * nb));
      chk({31'h0, sck_o}, {31'h0, ctl[POLARITY_BIT]});
      chk({31'h0, sck_oe}, 32'h1);
      $display("Test master format %0d done", i);
    end
    ctl = 16'h0;
    ctl[EDGE_SELECT_BIT] = 1'b1;
    ctl[MASTER_BIT] = 1'b1;
    ahb(1'b1, ADDR_CTRL, ctl);
    for (int i = 0; i < 16; i++) ahb(1'b1, ADDR_TXDATA, 16'(i));
    ahb(1'b0, ADDR_STATUS, 16'h0);
    chk(rd_r, 32'h22);
    ctl[CTRL_ENABLE_BIT] = 1'b1;
    ahb(1'b1, ADDR_CTRL, ctl);
    ahb(1'b1, ADDR_TXDATA, 16'h00AA);
    poll(32'h1D, 32'h1C);
    ahb(1'b0, ADDR_RXDATA, 16'h0);
    poll(32'h1F, 32'h04);
    $display("Test buffer done");
    slv <= 1'b1;
    ctl = 16'h0;
    ctl[CTRL_ENABLE_BIT] = 1'b1;
    ctl[SS_ENABLE_BIT] = 1'b1;
    ctl[EDGE_SELECT_BIT] = 1'b1;
    ahb(1'b1, ADDR_CTRL, ctl);
    repeat (5) @(posedge clk);
    chk({31'h0, sdo_oe}, 32'h0);
    ss_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk({31'h0, sdo_oe}, 32'h1);
    for (int b = 7; b >= 0; b--) begin
      bsdi <= 1'(8'h96 >> b);
      repeat (4) @(posedge clk);
      sck_i <= 1'b1;
      repeat (4) @(posedge clk);
      sck_i <= 1'b0;
    end
    bsdi <= 1'b1;
    repeat (8) @(posedge clk);
    ss_n <= 1'b1;
    poll(32'h8, 32'h8);
    ahb(1'b0, ADDR_RXDATA, 16'h0);
    chk(rd_r, 32'h96);
    chk({31'h0, sck_oe}, 32'h0);
    ctl[SS_ENABLE_BIT] = 1'b0;
    ahb(1'b1, ADDR_CTRL, ctl);
    repeat (5) @(posedge clk);
    chk({31'h0, sdo_oe}, 32'h1);
    ctl = 16'h0;
    ahb(1'b1, ADDR_CTRL, ctl);
    ahb(1'b1, ADDR_TXDATA, 16'h005A);
    sck_i <= 1'b1;
    repeat (5) @(posedge clk);
    ctl[CTRL_ENABLE_BIT] = 1'b1;
    ctl[POLARITY_BIT] = 1'b1;
    ahb(1'b1, ADDR_CTRL, ctl);
    repeat (5) @(posedge clk);
    for (int b = 7; b >= 0; b--) begin
      bsdi <= 1'(8'h3C >> b);
      sck_i <= 1'b0;
      repeat (4) @(posedge clk);
      rxw = {rxw[6:0], sdo_o};
      sck_i <= 1'b1;
      repeat (4) @(posedge clk);
    end
    poll(32'h8, 32'h8);
    ahb(1'b0, ADDR_RXDATA, 16'h0);
    chk(rd_r, 32'h3C);
    chk({24'h0, rxw}, 32'h5A);
    $display("Test slave done");
    end_sim();
  end
endmodule : spi_frame_format_control_bench

// ===== tb/spi_frame_port_sva.sv
`timescale 1ns/1ps
module spi_frame_port_sva
  import spi_frame_pkg::*;
#(
  parameter int HALF_CYCLES = DEFAULT_HALF_CYCLES
) (
  input wire logic CLK, // Clock
  input wire logic RESET_N, // Reset
  input wire logic HSEL, // Select
  input wire logic [31:0] HADDR, // Address
  input wire logic [1:0] HTRANS, // Transfer
  input wire logic HWRITE, // Write
  input wire logic [31:0] HWDATA, // Write data
  input wire logic HREADY, // Bus ready
  input wire logic HREADYOUT, // Ready
  input wire logic SCK_O, // Clock out
  input wire logic SCK_OE, // Clock enable
  input wire logic SDO_O, // Data out
  input wire logic SDO_OE, // Data enable
  input wire logic SLAVE_SELECT_PIN_N // Slave select
);
  logic pend_r;
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_q;
  int act_r;
  logic st;
  logic en;
  logic mst;
  logic pol;
  assign st = ctrl_r == ctrl_q;
  assign en = ctrl_r[CTRL_ENABLE_BIT];
  assign mst = ctrl_r[MASTER_BIT];
  assign pol = ctrl_r[POLARITY_BIT];
  // Shadow of the control register, and length of the current active clock level
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pend_r <= 1'b0;
      ctrl_r <= CTRL_RESET;
      ctrl_q <= CTRL_RESET;
      act_r <= 0;
    end else begin
      if (pend_r && HREADYOUT) ctrl_r <= HWDATA[15:0] & CTRL_MASK;
      if (HREADY) pend_r <= HSEL && HTRANS[1] && HWRITE && HADDR[7:0] == ADDR_CTRL;
      ctrl_q <= ctrl_r;
      act_r <= (st && SCK_OE && SCK_O != pol) ? act_r + 1 : 0;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  property p_slave_no_clk; !(en && mst) && !$past(en && mst) |-> !SCK_OE; endproperty
  a_slave_no_clk: assert property (p_slave_no_clk) else $error("clock driven outside master role");
  property p_master_clk; en && mst && st |-> SCK_OE; endproperty
  a_master_clk: assert property (p_master_clk) else $error("master not driving clock");
  property p_master_role; en && mst && st |-> SDO_OE; endproperty
  a_master_role: assert property (p_master_role) else $error("master not driving data");
  property p_active_half; act_r <= HALF_CYCLES; endproperty
  a_active_half: assert property (p_active_half) else $error("clock held active too long");
  property p_idle_start; $rose(SCK_OE) && ctrl_r[EDGE_SELECT_BIT] |-> SCK_O == pol; endproperty
  a_idle_start: assert property (p_idle_start) else $error("clock not at idle level");
  property p_edge; st && SCK_OE && $changed(SDO_O) |-> (SCK_O == pol) == ctrl_r[EDGE_SELECT_BIT]; endproperty
  a_edge: assert property (p_edge) else $error("data changed on wrong clock edge");
  property p_ss_off; (en && !mst && ctrl_r[SS_ENABLE_BIT] && st && SLAVE_SELECT_PIN_N) [*4] |-> !SDO_OE; endproperty
  a_ss_off: assert property (p_ss_off) else $error("data driven while deselected");
  property p_ss_unused; (en && !mst && !ctrl_r[SS_ENABLE_BIT] && st) [*2] |-> SDO_OE; endproperty
  a_ss_unused: assert property (p_ss_unused) else $error("select pin not ignored");
  c_frame: cover property (SCK_OE && SCK_O != pol);
  c_word: cover property (SCK_OE && ctrl_r[WORD_WIDTH_BIT]);
  c_slave: cover property (en && !mst && !SLAVE_SELECT_PIN_N && SDO_OE);
endmodule : spi_frame_port_sva

bind spi_frame_port spi_frame_port_sva #(.HALF_CYCLES(HALF_CYCLES)) i_spi_frame_port_sva (.CLK(CLK),
  .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
  .HREADY(HREADY), .HREADYOUT(HREADYOUT), .SCK_O(SCK_O), .SCK_OE(SCK_OE), .SDO_O(SDO_O), .SDO_OE(SDO_OE),
  .SLAVE_SELECT_PIN_N(SLAVE_SELECT_PIN_N));

// ===== tb/spi_partner.sv
`timescale 1ns/1ps
module spi_partner (
  input wire logic load, // Load word, clear counts
  input wire logic sck, // Serial clock wire
  input wire logic sdo, // Data from master
  input wire logic pol, // Clock idle level
  input wire logic edge_sel, // Edge select
  input wire logic [15:0] tx_word, // Word to send, msb first
  output logic sdi, // Data to master
  output logic [15:0] rx_word, // Captured bits
  output int edges // Clock transitions seen
);
  logic [15:0] sh = 16'h0;
  logic out_r = 1'b0;
  initial edges = 0;
  assign sdi = edge_sel ? sh[15] : out_r;
  always @(posedge load) begin
    sh = tx_word;
    out_r = ~tx_word[15];
    rx_word = 16'h0;
    edges = 0;
  end
  // Shift on one edge, capture on the other; stale bits are inverted
  always @(sck) begin
    edges = edges + 1;
    if ((sck != pol) ^ edge_sel) begin
      out_r = sh[15];
      sh = {sh[14:0], ~sh[15]};
    end else begin
      rx_word = {rx_word[14:0], sdo};
    end
  end
endmodule : spi_partner

// ===== verilog/spi_frame_pkg.sv
package spi_frame_pkg;

  // Register byte offsets on the AHB-Lite window
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TXDATA = 8'h04;
  localparam logic [7:0] ADDR_RXDATA = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // Control register fields
  localparam int CTRL_ENABLE_BIT = 15;
  localparam int WORD_WIDTH_BIT = 10;
  localparam int SAMPLE_PHASE_BIT = 9;
  localparam int EDGE_SELECT_BIT = 8;
  localparam int SS_ENABLE_BIT = 7;
  localparam int POLARITY_BIT = 6;
  localparam int MASTER_BIT = 5;
  localparam logic [15:0] CTRL_MASK = 16'h87E0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TX_FULL_BIT = 1;
  localparam int STAT_TX_EMPTY_BIT = 2;
  localparam int STAT_RX_VALID_BIT = 3;
  localparam int STAT_RX_OVF_BIT = 4;
  localparam int STAT_SS_LEVEL_BIT = 5;

  // Frame sizes and serial timing
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] HALF_LAST_BYTE = 5'h0F;
  localparam logic [4:0] HALF_LAST_WORD = 5'h1F;
  localparam int DEFAULT_HALF_CYCLES = 4;
  localparam int DEFAULT_FIFO_DEPTH = 16;
  localparam int DATA_WIDTH = 16;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b01,
    ENG_SHIFT = 2'b10
  } engine_e;

endpackage : spi_frame_pkg

// ===== verilog/spi_frame_port.sv
// Notes on behaviour
// RQ1 - With the word width select cleared every frame carries 8 bits.
// RQ2 - With the word width select set every frame carries 16 bits.
// RQ3 - As master, input is sampled at the end of each bit time when the sample phase is 1, else mid-bit.
// RQ4 - Software keeps the sample phase cleared whenever the port runs as slave.
// RQ5 - Output data changes on the active-to-idle clock edge when edge select is 1, else on idle-to-active.
// RQ6 - As slave with slave select enabled the slave select pin gates the link, otherwise the pin is ignored.
// RQ7 - Clock polarity 1 means clock idles high and is active low, polarity 0 the reverse.
// RQ8 - The master role select bit picks master (1) or slave (0) operation.
// RQ9 - As master the port drives the serial clock, as slave it only receives it and never drives it.
`timescale 1ns/1ps
module spi_word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Async reset, active low
  input wire logic in_valid, // Write request
  output logic in_ready, // Space available
  input wire logic [WIDTH-1:0] in_data, // Write word
  output logic out_valid, // Word available
  input wire logic out_ready, // Read request
  output logic [WIDTH-1:0] out_data // Head word
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_s;
  fifo_s s_r;
  fifo_s s_nxt;
  logic push;
  logic pop;
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
    $error("FIFO depth must be a power of two of at least 2");
  end
  assign in_ready = (s_r.cnt != (AW + 1)'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign out_data = s_r.mem[s_r.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wr] = in_data;
      s_nxt.wr = s_r.wr + 1'b1;
    end
    if (pop) begin
      s_nxt.rd = s_r.rd + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : spi_word_fifo

module spi_frame_port
  import spi_frame_pkg::*;
#(
  parameter int HALF_CYCLES = DEFAULT_HALF_CYCLES,
  parameter int FIFO_DEPTH = DEFAULT_FIFO_DEPTH
) (
  input wire logic CLK, // System clock
  input wire logic RESET_N, // Async reset, active low
  input wire logic HSEL, // AHB slave select
  input wire logic [31:0] HADDR, // AHB address
  input wire logic [1:0] HTRANS, // AHB transfer type
  input wire logic HWRITE, // AHB write
  input wire logic [2:0] HSIZE, // AHB size, words only
  input wire logic [31:0] HWDATA, // AHB write data
  input wire logic HREADY, // AHB bus ready
  output logic [31:0] HRDATA, // AHB read data
  output logic HREADYOUT, // AHB slave ready
  output logic HRESP, // AHB response, always OKAY
  input wire logic SCK_I, // Serial clock pin in
  output logic SCK_O, // Serial clock pin out
  output logic SCK_OE, // Serial clock drive enable
  input wire logic SDI, // Serial data in
  output logic SDO_O, // Serial data out
  output logic SDO_OE, // Serial data drive enable
  input wire logic SLAVE_SELECT_PIN_N // Slave select pin, active low
);
  if (HALF_CYCLES < 3 || HALF_CYCLES > 65535) begin : g_half_check
    $error("HALF_CYCLES must lie in 3..65535");
  end
  localparam logic [15:0] HALF_LAST = 16'(HALF_CYCLES - 1);
  typedef struct packed {
    engine_e eng;
    logic [15:0] ctrl;
    logic sck_m;
    logic sck_q;
    logic sck_p;
    logic sdi_m;
    logic sdi_q;
    logic ss_m;
    logic ss_q;
    logic [15:0] tx_sh;
    logic [15:0] rx_sh;
    logic [15:0] rx_data;
    logic tx_loaded;
    logic rx_valid;
    logic rx_ovf;
    logic [4:0] bit_cnt;
    logic [4:0] half;
    logic [15:0] div;
    logic sck_o;
    logic sck_oe;
    logic sdo_o;
    logic sdo_oe;
    logic dp_pend;
    logic dp_write;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } port_s;
  port_s s_r;
  port_s s_nxt;
  logic tx_push;
  logic tx_ready;
  logic tx_valid;
  logic tx_pop;
  logic [15:0] tx_head;

  function automatic logic [4:0] frame_bits(input logic wide);
    frame_bits = wide ? WORD_BITS : BYTE_BITS; // [RQ1] [RQ2]
  endfunction : frame_bits

  function automatic logic [4:0] half_last(input logic wide);
    half_last = wide ? HALF_LAST_WORD : HALF_LAST_BYTE; // [RQ1] [RQ2]
  endfunction : half_last

  // Clock level for a given half bit time
  function automatic logic sck_level(input logic [4:0] h, input logic cke, input logic cpol);
    sck_level = cpol ^ (h[0] ^ ~cke); // [RQ5] [RQ7]
  endfunction : sck_level

  // Left-aligned transmit word
  function automatic logic [15:0] align_tx(input logic [15:0] d, input logic wide);
    align_tx = wide ? d : {d[7:0], 8'h00}; // [RQ1] [RQ2]
  endfunction : align_tx

  spi_word_fifo #(
    .WIDTH(DATA_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(CLK),
    .rst_n(RESET_N),
    .in_valid(tx_push),
    .in_ready(tx_ready),
    .in_data(HWDATA[15:0]),
    .out_valid(tx_valid),
    .out_ready(tx_pop),
    .out_data(tx_head)
  );

  always_comb begin
    logic [15:0] rx_new;
    logic done;
    logic bus_done;
    logic en;
    logic wide;
    logic input_sample_phase;
    logic cke;
    logic cpol;
    logic ss_act;
    logic lead;
    logic trail;
    logic smp_edge;
    logic chg_edge;
    logic busy;
    rx_new = s_r.rx_sh;
    done = 1'b0;
    bus_done = 1'b0;
    en = s_r.ctrl[CTRL_ENABLE_BIT];
    wide = s_r.ctrl[WORD_WIDTH_BIT];
    input_sample_phase = s_r.ctrl[SAMPLE_PHASE_BIT];
    cke = s_r.ctrl[EDGE_SELECT_BIT];
    cpol = s_r.ctrl[POLARITY_BIT];
    ss_act = !s_r.ctrl[SS_ENABLE_BIT] || !s_r.ss_q; // [RQ6]
    lead = (s_r.sck_q != s_r.sck_p) && (s_r.sck_q != cpol); // [RQ7]
    trail = (s_r.sck_q != s_r.sck_p) && (s_r.sck_q == cpol); // [RQ7]
    smp_edge = cke ? lead : trail; // [RQ4]
    chg_edge = cke ? trail : lead; // [RQ5]
    busy = s_r.ctrl[MASTER_BIT] ? (s_r.eng == ENG_SHIFT) : (s_r.bit_cnt != 5'h00);
    tx_push = 1'b0;
    tx_pop = 1'b0;
    s_nxt = s_r;
    s_nxt.resp = 1'b0;
    // Pin synchronisers
    s_nxt.sck_m = SCK_I;
    s_nxt.sck_q = s_r.sck_m;
    s_nxt.sck_p = s_r.sck_q;
    s_nxt.sdi_m = SDI;
    s_nxt.sdi_q = s_r.sdi_m;
    s_nxt.ss_m = SLAVE_SELECT_PIN_N;
    s_nxt.ss_q = s_r.ss_m;
    // Bus data phase; a TX write waits while the FIFO is full
    if (s_r.dp_pend) begin
      bus_done = 1'b1;
      s_nxt.rdata = 32'h0000_0000;
      if (s_r.dp_write) begin
        case (s_r.dp_addr)
          ADDR_CTRL: begin
            s_nxt.ctrl = HWDATA[15:0] & CTRL_MASK;
          end
          ADDR_TXDATA: begin
            tx_push = 1'b1;
            bus_done = tx_ready;
          end
          default: begin
          end
        endcase
      end else begin
        case (s_r.dp_addr)
          ADDR_CTRL: begin
            s_nxt.rdata = {16'h0000, s_r.ctrl};
          end
          ADDR_RXDATA: begin
            s_nxt.rdata = {16'h0000, s_r.rx_data};
            s_nxt.rx_valid = 1'b0;
            s_nxt.rx_ovf = 1'b0;
          end
          ADDR_STATUS: begin
            s_nxt.rdata[STAT_BUSY_BIT] = busy;
            s_nxt.rdata[STAT_TX_FULL_BIT] = !tx_ready;
            s_nxt.rdata[STAT_TX_EMPTY_BIT] = !tx_valid;
            s_nxt.rdata[STAT_RX_VALID_BIT] = s_r.rx_valid;
            s_nxt.rdata[STAT_RX_OVF_BIT] = s_r.rx_ovf;
            s_nxt.rdata[STAT_SS_LEVEL_BIT] = s_r.ss_q;
          end
          default: begin
          end
        endcase
      end
    end
    if (bus_done) begin
      s_nxt.dp_pend = 1'b0;
      s_nxt.ready = 1'b1;
    end
    if (HSEL && HTRANS[1] && HREADY) begin
      s_nxt.dp_pend = 1'b1;
      s_nxt.dp_write = HWRITE;
      s_nxt.dp_addr = HADDR[7:0];
      s_nxt.ready = 1'b0;
    end
    // Serial engine
    if (!en) begin
      s_nxt.eng = ENG_IDLE;
      s_nxt.bit_cnt = 5'h00;
      s_nxt.half = 5'h00;
      s_nxt.div = 16'h0000;
      s_nxt.sck_o = cpol; // [RQ7]
      s_nxt.sck_oe = 1'b0;
      s_nxt.sdo_oe = 1'b0;
    end else if (s_r.ctrl[MASTER_BIT]) begin // [RQ8]
      s_nxt.sck_oe = 1'b1; // [RQ9]
      s_nxt.sdo_oe = 1'b1;
      s_nxt.bit_cnt = 5'h00;
      case (s_r.eng)
        ENG_IDLE: begin
          s_nxt.sck_o = cpol; // [RQ7]
          if (tx_valid) begin
            tx_pop = 1'b1;
            s_nxt.tx_sh = align_tx(tx_head, wide);
            s_nxt.tx_loaded = 1'b0;
            s_nxt.rx_sh = 16'h0000;
            s_nxt.half = 5'h00;
            s_nxt.div = 16'h0000;
            s_nxt.eng = ENG_SHIFT;
            s_nxt.sck_o = sck_level(5'h00, cke, cpol); // [RQ5] [RQ9]
          end
        end
        ENG_SHIFT: begin
          if (s_r.div == HALF_LAST) begin
            s_nxt.div = 16'h0000;
            if (s_r.half[0] == input_sample_phase) begin // [RQ3]
              rx_new = {s_r.rx_sh[14:0], s_r.sdi_q};
              s_nxt.rx_sh = rx_new;
            end
            if (s_r.half == half_last(wide)) begin // [RQ1] [RQ2]
              done = 1'b1;
              s_nxt.eng = ENG_IDLE;
              s_nxt.sck_o = cpol; // [RQ7]
            end else begin
              if (s_r.half[0]) begin
                s_nxt.tx_sh = {s_r.tx_sh[14:0], 1'b0}; // [RQ5]
              end
              s_nxt.half = s_r.half + 5'h01;
              s_nxt.sck_o = sck_level(s_r.half + 5'h01, cke, cpol); // [RQ9]
            end
          end else begin
            s_nxt.div = s_r.div + 16'h0001;
          end
        end
        default: begin
          s_nxt.eng = ENG_IDLE;
        end
      endcase
    end else begin
      s_nxt.eng = ENG_IDLE;
      s_nxt.sck_oe = 1'b0; // [RQ9]
      s_nxt.sck_o = cpol;
      s_nxt.sdo_oe = ss_act; // [RQ6]
      if (!ss_act) begin
        s_nxt.bit_cnt = 5'h00; // [RQ6]
      end else if (smp_edge) begin // [RQ4]
        rx_new = {s_r.rx_sh[14:0], s_r.sdi_q};
        s_nxt.rx_sh = rx_new;
        if (s_r.bit_cnt + 5'h01 == frame_bits(wide)) begin // [RQ1] [RQ2]
          done = 1'b1;
          s_nxt.bit_cnt = 5'h00;
          s_nxt.tx_loaded = 1'b0;
          s_nxt.tx_sh = 16'h0000;
        end else begin
          s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;
        end
      end else if (chg_edge && s_r.bit_cnt != 5'h00) begin
        s_nxt.tx_sh = {s_r.tx_sh[14:0], 1'b0}; // [RQ5]
      end
      if (!done && s_nxt.bit_cnt == 5'h00 && !s_r.tx_loaded && tx_valid) begin
        tx_pop = 1'b1;
        s_nxt.tx_sh = align_tx(tx_head, wide);
        s_nxt.tx_loaded = 1'b1;
      end
    end
    s_nxt.sdo_o = s_nxt.tx_sh[15];

    // Received word; a new word beats a read clear
    if (done) begin
      s_nxt.rx_data = wide ? rx_new : {8'h00, rx_new[7:0]}; // [RQ1] [RQ2]
      if (s_r.rx_valid) begin
        s_nxt.rx_ovf = 1'b1;
      end
      s_nxt.rx_valid = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_r <= '0;
      s_r.eng <= ENG_IDLE;
      s_r.ctrl <= CTRL_RESET;
      s_r.ready <= 1'b1;
      s_r.sck_m <= 1'b0;
      s_r.ss_m <= 1'b1;
      s_r.ss_q <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign HRDATA = s_r.rdata;
  assign HREADYOUT = s_r.ready;
  assign HRESP = s_r.resp;
  assign SCK_O = s_r.sck_o;
  assign SCK_OE = s_r.sck_oe;
  assign SDO_O = s_r.sdo_o;
  assign SDO_OE = s_r.sdo_oe;

endmodule : spi_frame_port
